// file: tsmo_pkg.sv
// Constants and types shared by the triple stepper motion controller.
// Assumes one 10 MHz core clock and a synchronous active-high reset.
package tsmo_pkg;
    // ========================================================
    // Clock and timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int MOTION_TICK_NS = 100000;
    localparam int TICK_CYC = MOTION_TICK_NS / CLK_PERIOD_NS;
    localparam int CHAIN_DIV = 16;
    localparam int CHAIN_HALF = CHAIN_DIV / 2;

    // ========================================================
    // Datagram layout
    localparam int HOST_DG_W = 32;
    localparam int ADDR_MSB = 31;
    localparam int ADDR_LSB = 25;
    localparam int RW_BIT = 24;
    localparam int DATA_W = 24;
    localparam int CHAIN_MAX_W = 64;
    localparam int CHAIN_BUF_W = 48;

    // ========================================================
    // Register indices
    localparam int MOTORS = 3;
    localparam logic [2:0] OFS_X_TGT = 3'h0;
    localparam logic [2:0] OFS_X_ACT = 3'h1;
    localparam logic [2:0] OFS_V_MIN = 3'h2;
    localparam logic [2:0] OFS_V_MAX = 3'h3;
    localparam logic [2:0] OFS_V_TGT = 3'h4;
    localparam logic [2:0] OFS_V_ACT = 3'h5;
    localparam logic [2:0] OFS_A_MAX = 3'h6;
    localparam logic [2:0] OFS_MODE = 3'h7;
    localparam logic [6:0] A_MOTOR_END = 7'h18;
    localparam logic [6:0] A_INT_MASK = 7'h18;
    localparam logic [6:0] A_REF_MODE = 7'h19;
    localparam logic [6:0] A_POLARITY = 7'h1a;
    localparam logic [6:0] A_CHAIN_LEN = 7'h1b;
    localparam logic [6:0] A_CHAIN_LO = 7'h1c;
    localparam logic [6:0] A_CHAIN_HI = 7'h1d;

    // ========================================================
    // Field positions and reset values
    localparam int POL_CSEL = 0;
    localparam int POL_CDATA = 1;
    localparam int POL_INT = 2;
    localparam logic [6:0] CHAIN_LEN_RST = 7'h30;
    localparam logic [6:0] CHAIN_LEN_MAX = 7'h40;
    localparam logic [5:0] INT_MASK_RST = 6'h00;
    localparam logic REF_MODE_RST = 1'h0;

    // ========================================================
    // Types
    typedef enum logic [1:0] {
        trapezoid_positioning_mode,
        exponential_decel_positioning_mode,
        limited_speed_mode,
        unlimited_host_speed_mode
    } tsmo_mode_t;

    typedef enum logic {ch_idle, ch_shift} tsmo_chain_t;
endpackage

// file: tsmo_core.sv
// Three-motor motion core with host datagram port and driver-chain shifter.
// Assumes all inputs synchronous to core_clk_in; host uses SPI mode 0, MSB first.
module tsmo_core #(
    parameter int V_W = 12
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic srst_in,
    // Host serial link
    input wire logic host_select_n_in,
    input wire logic host_sck_in,
    input wire logic host_sdi_in,
    output logic host_serial_out,
    // Driver chain link
    output logic chain_select_n_out,
    output logic chain_sck_out,
    output logic chain_sdo_out,
    input wire logic chain_sdi_in,
    // Reference switches
    input wire logic home_switch_in_one,
    input wire logic home_switch_in_two,
    input wire logic home_switch_in_three,
    // Motor state
    output logic [2:0] target_reached_out
);
    if (V_W < 4 || V_W > 24) begin : g_chk
        $error("V_W must lie in 4..24");
    end

    // ========================================================
    // State
    typedef struct packed {
        logic hsel_prev;
        logic hsck_prev;
        logic [5:0] hcnt;
        logic [31:0] hrx;
        logic [31:0] htx;
        logic [23:0] rd;
        logic [2:0][23:0] x_tgt;
        logic [2:0][23:0] x_act;
        logic [2:0][V_W-1:0] v_min;
        logic [2:0][V_W-1:0] v_max;
        logic [2:0][V_W-1:0] v_tgt;
        logic [2:0][V_W-1:0] v_act;
        logic [2:0][V_W-1:0] a_max;
        tsmo_pkg::tsmo_mode_t [2:0] mode;
        logic [5:0] int_mask;
        logic ref_alt;
        logic [2:0] pol;
        logic [6:0] ch_len;
        logic [9:0] tick_cnt;
        logic tick;
        tsmo_pkg::tsmo_chain_t ch_st;
        logic [2:0] ch_div;
        logic [6:0] ch_bits;
        logic ch_pend;
        logic [63:0] ch_tx;
        logic [47:0] ch_rx;
        logic [47:0] ch_buf;
        logic host_so;
        logic ch_csn;
        logic ch_sck;
        logic ch_sdo;
        logic [2:0] reached;
    } tsmo_state_t;

    localparam int VLIM = 2 ** (V_W - 1) - 1;

    tsmo_state_t s_q;
    tsmo_state_t s_d;
    logic [2:0] ref_l;
    logic [2:0] ref_r;
    logic [2:0] reached_w;
    logic int_w;
    logic [7:0] status_w;

    // ========================================================
    // Helpers
    function automatic int toward(input int v, input int g, input int a);
        if (v < g) begin
            return (v + a > g) ? g : v + a;
        end
        return (v - a < g) ? g : v - a;
    endfunction

    // Next velocity of one motor for one motion tick
    function automatic int motion_v(input tsmo_pkg::tsmo_mode_t md, input int v,
                                    input int vt, input int vmax, input int amax,
                                    input longint d);
        int g;
        int r;
        int av;
        int ar;
        longint ad;
        av = (v < 0) ? -v : v;
        ad = (d < 0) ? -d : d;
        r = v;
        unique case (md)
            tsmo_pkg::unlimited_host_speed_mode: begin
                r = vt;
            end
            tsmo_pkg::limited_speed_mode: begin
                g = (vt > vmax) ? vmax : ((vt < -vmax) ? -vmax : vt);
                r = toward(v, g, amax);
            end
            tsmo_pkg::trapezoid_positioning_mode,
            tsmo_pkg::exponential_decel_positioning_mode: begin
                // Distance recomputed every tick, so a new target is simply followed
                g = (d > 0) ? vmax : ((d < 0) ? -vmax : 0);
                if (longint'(av) * av > 2 * longint'(amax) * ad) begin
                    g = 0; // Braking point of the trapezoid
                end
                if (md == tsmo_pkg::exponential_decel_positioning_mode && g == 0) begin
                    r = v - v / 8; // Decay by one eighth per tick
                    if (r == v) begin
                        r = toward(v, 0, 1);
                    end
                end else begin
                    r = toward(v, g, amax);
                end
                // Never step past the target
                ar = (r < 0) ? -r : r;
                if (longint'(ar) > ad) begin
                    r = int'(d);
                end
            end
        endcase
        return r;
    endfunction

    function automatic logic at_tgt(input int m);
        return s_q.mode[m] inside {tsmo_pkg::trapezoid_positioning_mode,
                                   tsmo_pkg::exponential_decel_positioning_mode} &&
               s_q.x_act[m] == s_q.x_tgt[m] && s_q.v_act[m] == '0;
    endfunction

    // ========================================================
    // Reference routing and status byte
    assign ref_l = s_q.ref_alt ? {1'b0, home_switch_in_three, home_switch_in_one}
                               : {home_switch_in_three, home_switch_in_two,
                                  home_switch_in_one};
    assign ref_r = s_q.ref_alt ? {2'b00, home_switch_in_two} : 3'b000;
    assign reached_w = {at_tgt(2), at_tgt(1), at_tgt(0)};
    assign int_w = |({ref_l, reached_w} & s_q.int_mask);
    assign status_w = {int_w, s_q.ch_st == tsmo_pkg::ch_shift, ref_l, reached_w};

    // ========================================================
    // Next-state logic
    always_comb begin
        int v_i;
        int vn;
        int vmax_i;
        longint d;
        logic [6:0] a;
        logic [23:0] w;
        v_i = 0;
        vn = 0;
        vmax_i = 0;
        d = 0;
        a = s_q.hrx[tsmo_pkg::ADDR_MSB:tsmo_pkg::ADDR_LSB];
        w = s_q.hrx[tsmo_pkg::DATA_W-1:0];
        s_d = s_q;
        s_d.hsel_prev = host_select_n_in;
        s_d.hsck_prev = host_sck_in;

        // Host port: response loads at select fall, shifts with the request
        if (!host_select_n_in && s_q.hsel_prev) begin
            s_d.htx = {status_w, s_q.rd};
            s_d.hcnt = '0;
        end else if (!host_select_n_in) begin
            if (host_sck_in && !s_q.hsck_prev) begin
                s_d.hrx = {s_q.hrx[30:0], host_sdi_in};
                if (s_q.hcnt != 6'h3f) begin
                    s_d.hcnt = s_q.hcnt + 6'h01;
                end
            end else if (!host_sck_in && s_q.hsck_prev && s_q.hcnt != '0) begin
                s_d.htx = {s_q.htx[30:0], 1'b0};
            end
        end

        // Datagram acts only when exactly 32 bits arrived
        if (host_select_n_in && !s_q.hsel_prev && s_q.hcnt == 6'(tsmo_pkg::HOST_DG_W)) begin
            if (s_q.hrx[tsmo_pkg::RW_BIT]) begin
                s_d.rd = '0;
                if (a < tsmo_pkg::A_MOTOR_END) begin
                    unique case (a[2:0])
                        tsmo_pkg::OFS_X_TGT: s_d.rd = s_q.x_tgt[a[4:3]];
                        tsmo_pkg::OFS_X_ACT: s_d.rd = s_q.x_act[a[4:3]];
                        tsmo_pkg::OFS_V_MIN: s_d.rd = 24'(s_q.v_min[a[4:3]]);
                        tsmo_pkg::OFS_V_MAX: s_d.rd = 24'(s_q.v_max[a[4:3]]);
                        tsmo_pkg::OFS_V_TGT: s_d.rd = 24'($signed(s_q.v_tgt[a[4:3]]));
                        tsmo_pkg::OFS_V_ACT: s_d.rd = 24'($signed(s_q.v_act[a[4:3]]));
                        tsmo_pkg::OFS_A_MAX: s_d.rd = 24'(s_q.a_max[a[4:3]]);
                        tsmo_pkg::OFS_MODE: s_d.rd = 24'(s_q.mode[a[4:3]]);
                    endcase
                end else if (a == tsmo_pkg::A_INT_MASK) begin
                    s_d.rd = 24'(s_q.int_mask);
                end else if (a == tsmo_pkg::A_REF_MODE) begin
                    s_d.rd = 24'(s_q.ref_alt);
                end else if (a == tsmo_pkg::A_POLARITY) begin
                    s_d.rd = 24'(s_q.pol);
                end else if (a == tsmo_pkg::A_CHAIN_LEN) begin
                    s_d.rd = 24'(s_q.ch_len);
                end else if (a == tsmo_pkg::A_CHAIN_LO) begin
                    s_d.rd = s_q.ch_buf[23:0];
                end else if (a == tsmo_pkg::A_CHAIN_HI) begin
                    s_d.rd = s_q.ch_buf[47:24];
                end
            end else if (a < tsmo_pkg::A_MOTOR_END) begin
                unique case (a[2:0])
                    tsmo_pkg::OFS_X_TGT: s_d.x_tgt[a[4:3]] = w;
                    tsmo_pkg::OFS_X_ACT: s_d.x_act[a[4:3]] = w;
                    tsmo_pkg::OFS_V_MIN: s_d.v_min[a[4:3]] = w[V_W-1:0];
                    tsmo_pkg::OFS_V_MAX: s_d.v_max[a[4:3]] = w[V_W-1:0];
                    tsmo_pkg::OFS_V_TGT: s_d.v_tgt[a[4:3]] = w[V_W-1:0];
                    tsmo_pkg::OFS_V_ACT: s_d.v_act[a[4:3]] = w[V_W-1:0];
                    tsmo_pkg::OFS_A_MAX: s_d.a_max[a[4:3]] = w[V_W-1:0];
                    tsmo_pkg::OFS_MODE: s_d.mode[a[4:3]] = tsmo_pkg::tsmo_mode_t'(w[1:0]);
                endcase
            end else if (a == tsmo_pkg::A_INT_MASK) begin
                s_d.int_mask = w[5:0];
            end else if (a == tsmo_pkg::A_REF_MODE) begin
                s_d.ref_alt = w[0];
            end else if (a == tsmo_pkg::A_POLARITY) begin
                s_d.pol = w[2:0];
            end else if (a == tsmo_pkg::A_CHAIN_LEN) begin
                // Zero or oversize lengths fall back to the longest frame
                s_d.ch_len = (w == '0 || w > 24'(tsmo_pkg::CHAIN_LEN_MAX)) ?
                             tsmo_pkg::CHAIN_LEN_MAX : w[6:0];
            end
        end

        // Driver chain: 8 cycles per half bit keeps the rate at clock/16
        if (s_q.ch_st == tsmo_pkg::ch_idle && s_q.ch_pend) begin
            s_d.ch_st = tsmo_pkg::ch_shift;
            s_d.ch_pend = 1'b0;
            s_d.ch_tx = {s_q.x_act[2][15:0], s_q.x_act[1][15:0], s_q.x_act[0][15:0], 16'h0000};
            s_d.ch_rx = '0;
            s_d.ch_div = '0;
            s_d.ch_bits = '0;
            s_d.ch_sck = 1'b0;
        end else if (s_q.ch_st == tsmo_pkg::ch_shift) begin
            s_d.ch_div = s_q.ch_div + 3'h1;
            if (s_q.ch_div == 3'(tsmo_pkg::CHAIN_HALF - 1)) begin
                s_d.ch_sck = !s_q.ch_sck;
                if (!s_q.ch_sck) begin
                    s_d.ch_rx = {s_q.ch_rx[46:0], chain_sdi_in}; // Last 48 survive
                    s_d.ch_bits = s_q.ch_bits + 7'h01;
                end else begin
                    s_d.ch_tx = {s_q.ch_tx[62:0], 1'b0};
                    if (s_q.ch_bits == s_q.ch_len) begin
                        s_d.ch_st = tsmo_pkg::ch_idle;
                        s_d.ch_buf = s_q.ch_rx;
                    end
                end
            end
        end

        // Motion tick
        s_d.tick = s_q.tick_cnt == 10'(tsmo_pkg::TICK_CYC - 1);
        s_d.tick_cnt = s_d.tick ? '0 : s_q.tick_cnt + 10'h001;
        if (s_q.tick) begin
            for (int m = 0; m < tsmo_pkg::MOTORS; m++) begin
                v_i = int'($signed(s_q.v_act[m]));
                vmax_i = int'(s_q.v_max[m]) > VLIM ? VLIM : int'(s_q.v_max[m]);
                d = longint'($signed(s_q.x_tgt[m])) - longint'($signed(s_q.x_act[m]));
                vn = motion_v(s_q.mode[m], v_i, int'($signed(s_q.v_tgt[m])), vmax_i,
                              int'(s_q.a_max[m]), d);
                // Left switch stops reverse travel, right switch forward travel
                if ((ref_l[m] && vn < 0) || (ref_r[m] && vn > 0)) begin
                    vn = 0;
                end
                s_d.v_act[m] = V_W'(vn);
                s_d.x_act[m] = s_q.x_act[m] + 24'(vn);
                if (vn != 0) begin
                    s_d.ch_pend = 1'b1; // Set wins over the launch clear
                end
            end
        end

        // Registered pins
        s_d.host_so = host_select_n_in ? (!int_w ^ s_q.pol[tsmo_pkg::POL_INT])
                                       : s_d.htx[31];
        s_d.ch_csn = (s_d.ch_st != tsmo_pkg::ch_shift) ^ s_q.pol[tsmo_pkg::POL_CSEL];
        s_d.ch_sdo = s_d.ch_tx[63] ^ s_q.pol[tsmo_pkg::POL_CDATA];
        s_d.reached = reached_w;
    end

    // ========================================================
    // State register
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            s_q <= '0; // Motors idle, ramp mode, zero speeds
            s_q.hsel_prev <= 1'b1;
            s_q.ref_alt <= tsmo_pkg::REF_MODE_RST;
            s_q.int_mask <= tsmo_pkg::INT_MASK_RST;
            s_q.ch_len <= tsmo_pkg::CHAIN_LEN_RST;
            s_q.host_so <= 1'b1;
            s_q.ch_csn <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign host_serial_out = s_q.host_so;
    assign chain_select_n_out = s_q.ch_csn;
    assign chain_sck_out = s_q.ch_sck;
    assign chain_sdo_out = s_q.ch_sdo;
    assign target_reached_out = s_q.reached;

    // ========================================================
    // Checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);

    chain_rate_a: assert property ($changed(chain_sck_out) |=> $stable(chain_sck_out)[*7])
        else $error("chain clock half period below 8 cycles");
    host_idle_a: assert property ($past(host_select_n_in) |->
        host_serial_out == $past(!int_w ^ s_q.pol[tsmo_pkg::POL_INT]))
        else $error("idle host output not interrupt");
    hold_mode_a: assert property (s_q.tick && s_q.mode[2] == tsmo_pkg::unlimited_host_speed_mode
        && !ref_l[2] && !ref_r[2] |=> s_q.v_act[2] == $past(s_q.v_tgt[2]))
        else $error("hold mode speed not applied");
    arrive_hold_a: assert property (s_q.tick && reached_w[0] && s_q.x_tgt[0] == s_d.x_tgt[0]
        |=> s_q.x_act[0] == $past(s_q.x_act[0]))
        else $error("motor left its reached target");
    vel_cap_a: assert property (s_q.tick && s_q.mode[1] == tsmo_pkg::limited_speed_mode
        && $signed(s_q.v_act[1]) >= 0 && $signed(s_q.v_tgt[1]) >= 0 && s_q.v_max[1] < V_W'(VLIM)
        && s_q.v_act[1] <= s_q.v_max[1] |=> s_q.v_act[1] <= s_q.v_max[1])
        else $error("velocity limit exceeded");
    chain_buf_a: assert property ($past(s_q.ch_st) == tsmo_pkg::ch_shift
        && s_q.ch_st == tsmo_pkg::ch_idle |-> s_q.ch_buf == $past(s_q.ch_rx))
        else $error("chain buffer not captured");
    short_dg_a: assert property (host_select_n_in && !s_q.hsel_prev
        && s_q.hcnt != 6'(tsmo_pkg::HOST_DG_W) |=> $stable(s_q.rd) && $stable(s_q.int_mask))
        else $error("short datagram acted upon");
    ref_map_a: assert property (!s_q.ref_alt |-> ref_l == {home_switch_in_three,
        home_switch_in_two, home_switch_in_one} && ref_r == 3'b000)
        else $error("default reference mapping wrong");
    csel_pol_a: assert property (s_q.ch_st == tsmo_pkg::ch_idle && !s_q.ch_pend
        |=> chain_select_n_out == !$past(s_q.pol[tsmo_pkg::POL_CSEL]))
        else $error("chain select polarity wrong");
    status_a: assert property (!host_select_n_in && s_q.hsel_prev
        |=> s_q.htx[31:24] == $past(status_w))
        else $error("status byte not loaded");

    chain_done_c: cover property (s_q.ch_st == tsmo_pkg::ch_shift ##1 s_q.ch_st == tsmo_pkg::ch_idle);
    host_dg_c: cover property (host_select_n_in && !s_q.hsel_prev && s_q.hcnt == 6'h20);
    reach_c: cover property (!reached_w[0] ##1 reached_w[0]);
endmodule

// file: tsmo_host_model.sv
// Host controller model for the four-wire host link of the motion core.
// Assumes core_clk_in runs freely; lines change only just after its rising edge.
module tsmo_host_model (
    // Clock
    input wire logic core_clk_in,
    // Host link
    output logic host_select_n_out,
    output logic host_sck_out,
    output logic host_sdi_out,
    input wire logic host_serial_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // ========================================
    // Idle levels: deselected, clock low
    initial begin
        host_select_n_out = 1'b1;
        host_sck_out = 1'b0;
        host_sdi_out = 1'b0;
    end

    // Wait whole clocks, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask

    // One frame of n bits, MSB first; clock high and low four clocks each
    task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
        int i;
        rx = 32'h00000000;
        tick(1);
        host_select_n_out = 1'b0;
        for (i = 0; i < n; i++) begin
            host_sdi_out = tx[31 - i];
            tick(4);
            rx[31 - i] = host_serial_in; // Answer arrives while request goes
            host_sck_out = 1'b1;
            tick(4);
            host_sck_out = 1'b0;
        end
        host_sdi_out = ~host_sdi_out; // Inverted data line shows no stale bit
        tick(4);
        host_select_n_out = 1'b1;
        tick(4); // Gap between frames, select back high
    endtask
endmodule

// file: test_triple_stepper_motion_overview.sv
// Self-checking bench for the three-motor motion core.
// Assumes the host model drives the host link; chain input answers ones in frames.
module test_triple_stepper_motion_overview;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_in, srst_in, sel_n, sck, sdi, ser_out, csel_n, csck, csdo, csdi;
    logic home_one, home_two, home_three, sck_q;
    logic [2:0] reached;
    logic [31:0] rx;
    logic [23:0] rd;
    int miscompares = 0;
    int checks = 0;
    int gap = 99;
    int k;
    typedef struct packed {logic [6:0] adr; logic [23:0] wr; logic [23:0] exp;} tsmo_row_t;
    localparam tsmo_row_t ROWS [8] = '{{7'h07, 24'h000001, 24'h000001},
        {7'h0f, 24'h000002, 24'h000002}, {7'h17, 24'h000003, 24'h000003},
        {7'h03, 24'h000abc, 24'h000abc}, {7'h04, 24'hfff800, 24'hfff800},
        {7'h1b, 24'h000000, 24'h000040}, {7'h18, 24'h00003f, 24'h00003f},
        {7'h07, 24'h000000, 24'h000000}};

    // ========================================
    // Design, host model, chain answering ones whenever chain select is low
    assign csdi = ~csel_n;
    tsmo_core i_dut (.core_clk_in(core_clk_in), .srst_in(srst_in), .host_select_n_in(sel_n),
        .host_sck_in(sck), .host_sdi_in(sdi), .host_serial_out(ser_out),
        .chain_select_n_out(csel_n), .chain_sck_out(csck), .chain_sdo_out(csdo),
        .chain_sdi_in(csdi), .home_switch_in_one(home_one), .home_switch_in_two(home_two),
        .home_switch_in_three(home_three), .target_reached_out(reached));
    tsmo_host_model i_host (.core_clk_in(core_clk_in), .host_select_n_out(sel_n),
        .host_sck_out(sck), .host_sdi_out(sdi), .host_serial_in(ser_out));

    // Clock and watchdog; a hang counts as a mismatch
    initial begin
        core_clk_in = 1'b0;
        forever #50 core_clk_in = ~core_clk_in;
    end
    initial begin
        #9500000;
        miscompares++;
        test_done();
    end

    // ========================================
    // Compare tasks and verdict
    task automatic chk_data(input string what, input logic [23:0] exp, input logic [23:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bits(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Register access; read data comes back one frame later
    task automatic wr(input logic [6:0] adr, input logic [23:0] d);
        i_host.xfer({adr, 1'b0, d}, 32, rx);
    endtask
    task automatic rdreg(input logic [6:0] adr);
        i_host.xfer({adr, 1'b1, 24'h000000}, 32, rx);
        i_host.xfer({tsmo_pkg::A_REF_MODE, 1'b1, 24'h000000}, 32, rx);
        rd = rx[23:0];
    endtask

    // Chain clock edges at least eight clocks apart
    always @(negedge core_clk_in) begin
        if (!srst_in && csck !== sck_q) begin
            chk_bits("chain half period", 8'h01, {7'h00, gap >= tsmo_pkg::CHAIN_HALF});
            gap = 0;
        end
        gap++;
        sck_q = csck;
    end

    // ========================================
    // Main sequence: reset, table, then hand-written cases
    initial begin
        srst_in = 1'b1;
        {home_one, home_two, home_three, sck_q} = 4'h0;
        repeat (6) @(posedge core_clk_in);
        #1 srst_in = 1'b0;
        i_host.tick(2);
        chk_bits("reached", 8'h07, {5'h00, reached});
        chk_bits("idle serial", 8'h01, {7'h00, ser_out});
        rdreg(tsmo_pkg::A_REF_MODE);
        chk_data("ref mode", 24'h000000, rd);
        rdreg(tsmo_pkg::A_CHAIN_LEN);
        chk_data("chain length", 24'h000030, rd);
        foreach (ROWS[r]) begin
            wr(ROWS[r].adr, ROWS[r].wr);
            rdreg(ROWS[r].adr);
            chk_data("register", ROWS[r].exp, rd);
        end
        i_host.xfer({7'h07, 1'b0, 24'h000002}, 31, rx); // Short frame, must be dropped
        rdreg(7'h07);
        chk_data("short frame", 24'h000000, rd);
        // Interrupt shown on the idle serial output, then inverted
        wr(tsmo_pkg::A_INT_MASK, 24'h000001);
        chk_bits("interrupt", 8'h00, {7'h00, ser_out});
        wr(tsmo_pkg::A_POLARITY, 24'h000004);
        chk_bits("inverted interrupt", 8'h01, {7'h00, ser_out});
        wr(tsmo_pkg::A_POLARITY, 24'h000001);
        i_host.tick(3);
        chk_bits("chain select", 8'h00, {7'h00, csel_n});
        wr(tsmo_pkg::A_POLARITY, 24'h000002);
        chk_bits("chain data idle", 8'h01, {7'h00, csdo});
        wr(tsmo_pkg::A_POLARITY, 24'h000000);
        wr(tsmo_pkg::A_INT_MASK, 24'h000000);
        // Reference inputs seen in the status bits
        home_two = 1'b1;
        rdreg(tsmo_pkg::A_REF_MODE);
        chk_bits("left switches", 8'h02, {5'h00, rx[29:27]});
        wr(tsmo_pkg::A_REF_MODE, 24'h000001);
        rdreg(tsmo_pkg::A_REF_MODE);
        chk_bits("alt left", 8'h00, {5'h00, rx[29:27]});
        {home_two, home_three} = 2'h1;
        rdreg(tsmo_pkg::A_REF_MODE);
        chk_bits("alt left three", 8'h02, {5'h00, rx[29:27]});
        home_three = 1'b0;
        wr(tsmo_pkg::A_REF_MODE, 24'h000000);
        // Ramp move of motor zero to twenty steps
        wr(7'h06, 24'h000001);
        wr(7'h03, 24'h000004);
        wr(7'h00, 24'h000014);
        rd = 24'h000000;
        for (k = 0; k < 60 && rd !== 24'h000014; k++) rdreg(7'h01);
        chk_data("position", 24'h000014, rd);
        i_host.tick(1200);
        chk_bits("reached after move", 8'h01, {7'h00, reached[0]});
        rdreg(tsmo_pkg::A_CHAIN_LO);
        chk_data("chain low", 24'hffffff, rd);
        rdreg(tsmo_pkg::A_CHAIN_HI);
        chk_data("chain high", 24'hffffff, rd);
        // Target changed in mid-move
        wr(7'h00, 24'h000028);
        i_host.tick(3000);
        wr(7'h00, 24'h00000a);
        for (k = 0; k < 60 && rd !== 24'h00000a; k++) rdreg(7'h01);
        chk_data("retarget", 24'h00000a, rd);
        test_done();
    end
endmodule
